/* File: hw/bsci_interp.sv */
// boot script command interpreter: parses the word stream, writes sections,
// keeps the checksum, runs jumps, and recovers from checksum mismatches
// assumes words, writes, jumps and seeks come from logic on clk
//
// Function
// - jump opcode: next word is target, start execution there
// - after jumped code finishes, resume with the following command
// - jump-and-close plus entry address, section count and byte count ends boot, reports entry and count match
// - keep 32-bit checksum over load and fill data while enabled
// - checksum enable and disable are single words, switch accumulation
// - checksum request parsed as opcode, expected value, seek value
// - compare checksum with expected; on match ignore seek, go on
// - on mismatch add negative seek to stream position to retry
// - restart command is one word, clears checksum to zero
// - master mode: own sequencer does restart and seek-back
// - single option failure reloads all sections, checks again
// - section load: opcode, address, size, then contents
// - section fill: opcode, address, size, width 8/16/32, pattern
`timescale 1ns/10ps

module bsci_interp (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // script word stream
   input wire logic [31:0] wordData,
   input wire logic wordValid,
   output logic wordReady,
   // boot mode: high when the device fetches its own script
   input wire logic masterMode,
   // memory write port
   output logic memWrValid,
   input wire logic memWrReady,
   output logic [31:0] memWrAddr,
   output logic [31:0] memWrData,
   output logic [3:0] memWrBe,
   // jump to loaded code
   output logic jumpReq,
   output logic [31:0] jumpAddr,
   input wire logic jumpDone,
   // own seek-back request in master mode
   output logic seekReq,
   output logic [31:0] seekAddr,
   input wire logic seekAck,
   // status
   output logic crcFail,
   output logic crcOn,
   output logic [31:0] crcValue,
   output logic [31:0] streamPos,
   output logic bootDone,
   output logic [31:0] entryAddr,
   output logic countMatch,
   output logic bootError
);

   // --------
   // helpers
   // --------
   // byte enables for the remaining byte count of a section
   function automatic logic [3:0] beMask(input logic [31:0] left);
      if (left >= bsci_pkg::WORD_BYTES) return bsci_pkg::BE_ALL;
      else if (left == 32'h00000003) return bsci_pkg::BE_3;
      else if (left == 32'h00000002) return bsci_pkg::BE_2;
      else return bsci_pkg::BE_1;
   endfunction : beMask

   // replicate a fill pattern of the given width over a word
   function automatic logic [31:0] replicate(input logic [31:0] pat,
                                             input logic [31:0] width);
      if (width == bsci_pkg::FILL_W8) return {4{pat[7:0]}};
      else if (width == bsci_pkg::FILL_W16) return {2{pat[15:0]}};
      else return pat;
   endfunction : replicate

   // --------
   // state
   // --------
   bsci_pkg::bsci_state_e state_reg, state_next;
   logic [31:0] opc_reg, opc_next;
   logic [31:0] arg_reg [0:3];
   logic [31:0] arg_next [0:3];
   logic [2:0] argIdx_reg, argIdx_next;
   logic [2:0] argNeed_reg, argNeed_next;
   logic [31:0] addr_reg, addr_next;
   logic [31:0] left_reg, left_next;
   logic [31:0] pat_reg, pat_next;
   logic wrValid_reg, wrValid_next;
   logic [31:0] wrAddr_reg, wrAddr_next;
   logic [31:0] wrData_reg, wrData_next;
   logic [3:0] wrBe_reg, wrBe_next;
   logic [31:0] crc_reg, crc_next;
   logic crcOn_reg, crcOn_next;
   logic crcFail_reg, crcFail_next;
   logic [31:0] pos_reg, pos_next;
   logic [31:0] jump_reg, jump_next;
   logic [31:0] seek_reg, seek_next;
   logic [31:0] entry_reg, entry_next;
   logic [31:0] sect_reg, sect_next;
   logic [31:0] bytes_reg, bytes_next;
   logic match_reg, match_next;
   logic slotFree;
   logic loadSlot;
   logic [31:0] slotData;
   logic [31:0] crcUpd;
   logic wordTake;

   // checksum of the word entering the write slot
   bsci_crc u_crc (
      .crcIn(crc_reg),
      .dataIn(slotData),
      .crcOut(crcUpd)
   );

   // --------
   // next-state logic
   // --------
   always_comb begin
      state_next = state_reg;
      opc_next = opc_reg;
      arg_next = arg_reg;
      argIdx_next = argIdx_reg;
      argNeed_next = argNeed_reg;
      addr_next = addr_reg;
      left_next = left_reg;
      pat_next = pat_reg;
      wrAddr_next = wrAddr_reg;
      wrData_next = wrData_reg;
      wrBe_next = wrBe_reg;
      crc_next = crc_reg;
      crcOn_next = crcOn_reg;
      crcFail_next = 1'b0;
      jump_next = jump_reg;
      seek_next = seek_reg;
      entry_next = entry_reg;
      sect_next = sect_reg;
      bytes_next = bytes_reg;
      match_next = match_reg;
      wordReady = 1'b0;
      loadSlot = 1'b0;
      slotData = wordData;
      slotFree = !wrValid_reg || memWrReady;
      wrValid_next = wrValid_reg && !memWrReady;
      unique case (state_reg)
         bsci_pkg::ST_OPCODE: begin
            // wait for writes to drain before taking the next opcode
            wordReady = !wrValid_reg;
            if (wordValid && !wrValid_reg) begin
               opc_next = wordData;
               argIdx_next = 3'h0;
               state_next = bsci_pkg::ST_ARGS;
               case (wordData)
                  bsci_pkg::OPC_SECTION_LOAD: argNeed_next = bsci_pkg::NARG_LOAD;
                  bsci_pkg::OPC_SECTION_FILL: argNeed_next = bsci_pkg::NARG_FILL;
                  bsci_pkg::OPC_JUMP: argNeed_next = bsci_pkg::NARG_JUMP;
                  bsci_pkg::OPC_JUMP_CLOSE: argNeed_next = bsci_pkg::NARG_CLOSE;
                  bsci_pkg::OPC_CRC_REQUEST: argNeed_next = bsci_pkg::NARG_CRC;
                  bsci_pkg::OPC_CRC_ENABLE: begin
                     crcOn_next = 1'b1;
                     state_next = bsci_pkg::ST_OPCODE;
                  end
                  bsci_pkg::OPC_CRC_DISABLE: begin
                     crcOn_next = 1'b0;
                     state_next = bsci_pkg::ST_OPCODE;
                  end
                  bsci_pkg::OPC_RESTART_CHECKSUM_CMD: begin
                     crc_next = bsci_pkg::CRC_INIT;
                     state_next = bsci_pkg::ST_OPCODE;
                  end
                  default: state_next = bsci_pkg::ST_ERROR;
               endcase
            end
         end
         bsci_pkg::ST_ARGS: begin
            // gather the fixed argument words of the command
            wordReady = 1'b1;
            if (wordValid) begin
               arg_next[argIdx_reg[1:0]] = wordData;
               argIdx_next = argIdx_reg + 3'h1;
               if (argIdx_reg + 3'h1 == argNeed_reg) begin
                  state_next = bsci_pkg::ST_EXEC;
               end
            end
         end
         bsci_pkg::ST_EXEC: begin
            addr_next = arg_reg[bsci_pkg::ARG_ADDR];
            left_next = arg_reg[bsci_pkg::ARG_SIZE];
            case (opc_reg)
               bsci_pkg::OPC_SECTION_LOAD,
               bsci_pkg::OPC_SECTION_FILL: begin
                  sect_next = sect_reg + 32'h00000001;
                  bytes_next = bytes_reg + arg_reg[bsci_pkg::ARG_SIZE];
                  pat_next = replicate(arg_reg[bsci_pkg::ARG_PATTERN],
                                       arg_reg[bsci_pkg::ARG_WIDTH]);
                  if (arg_reg[bsci_pkg::ARG_SIZE] == 32'h00000000) begin
                     state_next = bsci_pkg::ST_OPCODE;
                  end else if (opc_reg == bsci_pkg::OPC_SECTION_LOAD) begin
                     state_next = bsci_pkg::ST_LOAD;
                  end else if (arg_reg[bsci_pkg::ARG_WIDTH] ==
                                  bsci_pkg::FILL_W8 ||
                               arg_reg[bsci_pkg::ARG_WIDTH] ==
                                  bsci_pkg::FILL_W16 ||
                               arg_reg[bsci_pkg::ARG_WIDTH] ==
                                  bsci_pkg::FILL_W32) begin
                     state_next = bsci_pkg::ST_FILL;
                  end else begin
                     state_next = bsci_pkg::ST_ERROR;
                  end
               end
               bsci_pkg::OPC_JUMP: begin
                  jump_next = arg_reg[bsci_pkg::ARG_ADDR];
                  state_next = bsci_pkg::ST_JUMP;
               end
               bsci_pkg::OPC_JUMP_CLOSE: begin
                  entry_next = arg_reg[bsci_pkg::ARG_ADDR];
                  match_next = (arg_reg[bsci_pkg::ARG_NSECT] == sect_reg) &&
                               (arg_reg[bsci_pkg::ARG_NBYTES] == bytes_reg);
                  state_next = bsci_pkg::ST_DONE;
               end
               bsci_pkg::OPC_CRC_REQUEST: begin
                  if (arg_reg[bsci_pkg::ARG_EXPECT] == crc_reg) begin
                     state_next = bsci_pkg::ST_OPCODE;
                  end else begin
                     crcFail_next = 1'b1;
                     seek_next = pos_reg + arg_reg[bsci_pkg::ARG_SEEK];
                     if (masterMode) begin
                        crc_next = bsci_pkg::CRC_INIT;
                        state_next = bsci_pkg::ST_SEEK;
                     end else begin
                        state_next = bsci_pkg::ST_OPCODE;
                     end
                  end
               end
               default: state_next = bsci_pkg::ST_ERROR;
            endcase
         end
         bsci_pkg::ST_LOAD: begin
            // section contents go straight to the write slot
            wordReady = slotFree;
            loadSlot = wordValid && slotFree;
         end
         bsci_pkg::ST_FILL: begin
            slotData = pat_reg;
            loadSlot = slotFree;
         end
         bsci_pkg::ST_JUMP: begin
            if (jumpDone) begin
               state_next = bsci_pkg::ST_OPCODE;
            end
         end
         bsci_pkg::ST_SEEK: begin
            if (seekAck) begin
               state_next = bsci_pkg::ST_OPCODE;
            end
         end
         bsci_pkg::ST_DONE: begin
            state_next = bsci_pkg::ST_DONE;
         end
         bsci_pkg::ST_ERROR: begin
            state_next = bsci_pkg::ST_ERROR;
         end
      endcase
      // write slot fill and checksum update
      if (loadSlot) begin
         wrValid_next = 1'b1;
         wrAddr_next = addr_reg;
         wrData_next = slotData;
         wrBe_next = beMask(left_reg);
         addr_next = addr_reg + bsci_pkg::WORD_BYTES;
         if (crcOn_reg) begin
            crc_next = crcUpd;
         end
         if (left_reg > bsci_pkg::WORD_BYTES) begin
            left_next = left_reg - bsci_pkg::WORD_BYTES;
         end else begin
            left_next = 32'h00000000;
            state_next = bsci_pkg::ST_OPCODE;
         end
      end
      // stream position in bytes, moved back on a mismatch
      wordTake = wordReady && wordValid;
      if (crcFail_next) begin
         pos_next = seek_next;
      end else if (wordTake) begin
         pos_next = pos_reg + bsci_pkg::WORD_BYTES;
      end else begin
         pos_next = pos_reg;
      end
   end

   // --------
   // registers
   // --------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= bsci_pkg::ST_OPCODE;
         opc_reg <= 32'h00000000;
         for (int i = 0; i < 4; i++) begin
            arg_reg[i] <= 32'h00000000;
         end
         argIdx_reg <= 3'h0;
         argNeed_reg <= 3'h0;
         addr_reg <= 32'h00000000;
         left_reg <= 32'h00000000;
         pat_reg <= 32'h00000000;
         wrValid_reg <= 1'b0;
         wrAddr_reg <= 32'h00000000;
         wrData_reg <= 32'h00000000;
         wrBe_reg <= 4'h0;
         crc_reg <= bsci_pkg::CRC_INIT;
         crcOn_reg <= 1'b0;
         crcFail_reg <= 1'b0;
         pos_reg <= 32'h00000000;
         jump_reg <= 32'h00000000;
         seek_reg <= 32'h00000000;
         entry_reg <= 32'h00000000;
         sect_reg <= 32'h00000000;
         bytes_reg <= 32'h00000000;
         match_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         opc_reg <= opc_next;
         arg_reg <= arg_next;
         argIdx_reg <= argIdx_next;
         argNeed_reg <= argNeed_next;
         addr_reg <= addr_next;
         left_reg <= left_next;
         pat_reg <= pat_next;
         wrValid_reg <= wrValid_next;
         wrAddr_reg <= wrAddr_next;
         wrData_reg <= wrData_next;
         wrBe_reg <= wrBe_next;
         crc_reg <= crc_next;
         crcOn_reg <= crcOn_next;
         crcFail_reg <= crcFail_next;
         pos_reg <= pos_next;
         jump_reg <= jump_next;
         seek_reg <= seek_next;
         entry_reg <= entry_next;
         sect_reg <= sect_next;
         bytes_reg <= bytes_next;
         match_reg <= match_next;
      end
   end

   // --------
   // outputs
   // --------
   assign memWrValid = wrValid_reg;
   assign memWrAddr = wrAddr_reg;
   assign memWrData = wrData_reg;
   assign memWrBe = wrBe_reg;
   assign jumpReq = (state_reg == bsci_pkg::ST_JUMP);
   assign jumpAddr = jump_reg;
   assign seekReq = (state_reg == bsci_pkg::ST_SEEK);
   assign seekAddr = seek_reg;
   assign crcFail = crcFail_reg;
   assign crcOn = crcOn_reg;
   assign crcValue = crc_reg;
   assign streamPos = pos_reg;
   assign bootDone = (state_reg == bsci_pkg::ST_DONE);
   assign entryAddr = entry_reg;
   assign countMatch = match_reg;
   assign bootError = (state_reg == bsci_pkg::ST_ERROR);

endmodule : bsci_interp

/* File: pkg/bsci_pkg.sv */
// boot script command interpreter: opcodes, argument layout, crc constants
// assumes 32-bit script words and byte addressing of the stream position
package bsci_pkg;

   // --------
   // command opcodes
   // --------
   localparam logic [31:0] OPC_SECTION_LOAD = 32'h58535901;
   localparam logic [31:0] OPC_CRC_REQUEST = 32'h58535902;
   localparam logic [31:0] OPC_CRC_ENABLE = 32'h58535903;
   localparam logic [31:0] OPC_CRC_DISABLE = 32'h58535904;
   localparam logic [31:0] OPC_JUMP = 32'h58535905;
   localparam logic [31:0] OPC_JUMP_CLOSE = 32'h58535906;
   localparam logic [31:0] OPC_RESTART_CHECKSUM_CMD = 32'h58535908;
   localparam logic [31:0] OPC_SECTION_FILL = 32'h5853590A;

   // --------
   // argument counts and slots
   // --------
   localparam logic [2:0] NARG_LOAD = 3'h2;
   localparam logic [2:0] NARG_FILL = 3'h4;
   localparam logic [2:0] NARG_JUMP = 3'h1;
   localparam logic [2:0] NARG_CLOSE = 3'h3;
   localparam logic [2:0] NARG_CRC = 3'h2;
   localparam int ARG_ADDR = 0;
   localparam int ARG_SIZE = 1;
   localparam int ARG_WIDTH = 2;
   localparam int ARG_PATTERN = 3;
   localparam int ARG_NSECT = 1;
   localparam int ARG_NBYTES = 2;
   localparam int ARG_EXPECT = 0;
   localparam int ARG_SEEK = 1;

   // --------
   // fill widths, word size, byte enables
   // --------
   localparam logic [31:0] FILL_W8 = 32'h00000008;
   localparam logic [31:0] FILL_W16 = 32'h00000010;
   localparam logic [31:0] FILL_W32 = 32'h00000020;
   localparam logic [31:0] WORD_BYTES = 32'h00000004;
   localparam logic [3:0] BE_1 = 4'h1;
   localparam logic [3:0] BE_2 = 4'h3;
   localparam logic [3:0] BE_3 = 4'h7;
   localparam logic [3:0] BE_ALL = 4'hF;

   // --------
   // checksum: polynomial is a plain default, value arbitrary
   // --------
   localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
   localparam logic [31:0] CRC_INIT = 32'h00000000;

   // --------
   // interpreter states
   // --------
   typedef enum logic [3:0] {
      ST_OPCODE = 4'h0,
      ST_ARGS = 4'h1,
      ST_EXEC = 4'h2,
      ST_LOAD = 4'h3,
      ST_FILL = 4'h4,
      ST_JUMP = 4'h5,
      ST_SEEK = 4'h6,
      ST_DONE = 4'h7,
      ST_ERROR = 4'h8
   } bsci_state_e;

endpackage : bsci_pkg

/* File: hw/bsci_crc.sv */
// one-word checksum step: folds a 32-bit data word into the running value
// assumes a purely combinational use; the caller registers the result
`timescale 1ns/10ps

module bsci_crc (
   // running value and word
   input wire logic [31:0] crcIn,
   input wire logic [31:0] dataIn,
   // updated value
   output logic [31:0] crcOut
);

   // --------
   // msb-first shift of all 32 data bits
   // --------
   function automatic logic [31:0] crcStep(input logic [31:0] c,
                                           input logic [31:0] d);
      logic [31:0] r;
      logic fb;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         fb = r[31] ^ d[i];
         r = {r[30:0], 1'b0} ^ (fb ? bsci_pkg::CRC_POLY : 32'h00000000);
      end
      return r;
   endfunction : crcStep

   // combinational update
   always_comb begin
      crcOut = crcStep(crcIn, dataIn);
   end

endmodule : bsci_crc

/* File: dv/bsci_properties.sv */
// checker: timing relations at the interpreter ports
// assumes a bind onto bsci_interp, one clock domain
`timescale 1ns/10ps

module bsci_properties (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // stream and mode
   input wire logic wordReady,
   input wire logic masterMode,
   // memory write port
   input wire logic memWrValid,
   input wire logic memWrReady,
   input wire logic [31:0] memWrAddr,
   input wire logic [31:0] memWrData,
   input wire logic [3:0] memWrBe,
   // jump and seek
   input wire logic jumpReq,
   input wire logic [31:0] jumpAddr,
   input wire logic jumpDone,
   input wire logic seekReq,
   input wire logic [31:0] seekAddr,
   input wire logic seekAck,
   // status
   input wire logic crcFail,
   input wire logic crcOn,
   input wire logic [31:0] crcValue,
   input wire logic [31:0] streamPos,
   input wire logic bootDone,
   input wire logic [31:0] entryAddr,
   input wire logic bootError
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // one accepted write, then another word in the slot
   sequence wr_take;
      memWrValid && memWrReady;
   endsequence
   sequence wr_next;
      wr_take ##1 memWrValid;
   endsequence
   a_wr_hold: assert property (
      memWrValid && !memWrReady |=> memWrValid
      && $stable({memWrAddr, memWrData, memWrBe}))
      else $error("write not held");
   a_wr_step: assert property (
      wr_next |-> memWrAddr == $past(memWrAddr) + 32'h00000004)
      else $error("write address step wrong");
   a_jump_hold: assert property (
      jumpReq && !jumpDone |=> jumpReq && $stable(jumpAddr))
      else $error("jump dropped");
   a_jump_resume: assert property (jumpReq && jumpDone |=> !jumpReq)
      else $error("jump held after done");
   a_close_stay: assert property (
      bootDone |=> bootDone && !wordReady && $stable(entryAddr))
      else $error("boot end not final");
   a_fail_pulse: assert property (crcFail |=> !crcFail)
      else $error("mismatch flag held");
   a_seek_start: assert property (
      crcFail && masterMode |-> seekReq && seekAddr == streamPos)
      else $error("seek start wrong");
   a_seek_hold: assert property (
      seekReq && !seekAck |=> seekReq && $stable(seekAddr))
      else $error("seek dropped");
   a_error_stay: assert property (
      bootError |=> bootError && !wordReady)
      else $error("error state left");
   a_crc_frozen: assert property (
      !crcOn |=> $stable(crcValue) || crcValue == 32'h00000000)
      else $error("checksum moved");
endmodule : bsci_properties

/* File: dv/bsci_partner.sv */
// partner: memory write sink, jumped code, stream repositioning
// assumes the interpreter clock; slow adds random write stalls
`timescale 1ns/10ps

module bsci_partner (
   // clock, reset, pace
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slow,
   // memory write port
   input wire logic memWrValid,
   output logic memWrReady,
   // jump and seek handshakes
   input wire logic jumpReq,
   output logic jumpDone,
   input wire logic seekReq,
   output logic seekAck
);
   int seed = 27;
   logic [31:0] rnd;
   logic [3:0] waitCnt;
   // stalls, jumped code run time, seek delay
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         memWrReady <= 1'b1;
         waitCnt <= 4'h0;
         jumpDone <= 1'b0;
         seekAck <= 1'b0;
      end else begin
         rnd = $random(seed);
         memWrReady <= !slow || rnd[0] || !memWrValid;
         waitCnt <= (jumpReq || seekReq) ? waitCnt + 4'h1 : 4'h0;
         jumpDone <= jumpReq && !jumpDone && waitCnt == 4'h2;
         seekAck <= seekReq && !seekAck && waitCnt == 4'h3;
      end
   end
endmodule : bsci_partner

/* File: dv/testbench.sv */
// testbench: script words in, writes checked from a queue of notes
// assumes bsci_interp, bsci_partner and the checker are compiled first
`timescale 1ns/10ps

module testbench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] wordData = 32'h00000000;
   logic wordValid = 1'b0;
   logic masterMode = 1'b0;
   logic slow = 1'b0;
   logic wordReady, memWrValid, memWrReady, jumpReq, jumpDone, seekReq;
   logic seekAck, crcFail, crcOn, bootDone, countMatch, bootError;
   logic [31:0] memWrAddr, memWrData, jumpAddr, seekAddr, crcValue;
   logic [31:0] streamPos, entryAddr, pos, crcM, nsect, nbytes;
   logic [3:0] memWrBe;
   logic [67:0] wrQ[$];
   logic [67:0] note;
   logic crcEn = 1'b0;
   int err_total = 0, checked = 0, seed = 27, cyc = 0;

   always #50 clk = ~clk;

   bsci_interp i_dut (.clk(clk), .arst_n(arst_n), .wordData(wordData),
      .wordValid(wordValid), .wordReady(wordReady), .masterMode(masterMode),
      .memWrValid(memWrValid), .memWrReady(memWrReady),
      .memWrAddr(memWrAddr), .memWrData(memWrData), .memWrBe(memWrBe),
      .jumpReq(jumpReq), .jumpAddr(jumpAddr), .jumpDone(jumpDone),
      .seekReq(seekReq), .seekAddr(seekAddr), .seekAck(seekAck),
      .crcFail(crcFail), .crcOn(crcOn), .crcValue(crcValue),
      .streamPos(streamPos), .bootDone(bootDone), .entryAddr(entryAddr),
      .countMatch(countMatch), .bootError(bootError));
   bsci_partner i_partner (.clk(clk), .arst_n(arst_n), .slow(slow),
      .memWrValid(memWrValid), .memWrReady(memWrReady), .jumpReq(jumpReq),
      .jumpDone(jumpDone), .seekReq(seekReq), .seekAck(seekAck));

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic final_report();
      check("pendingWrites", 32'h0, wrQ.size());
      $display("TB counts: checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   function automatic logic [31:0] crc_step(input logic [31:0] c,
      input logic [31:0] d);
      logic [31:0] r;
      r = c ^ d;
      for (int i = 0; i < 32; i++)
         r = r[31] ? (r << 1) ^ bsci_pkg::CRC_POLY : r << 1;
      return r;
   endfunction : crc_step

   // offer one word and hold it until taken
   task automatic send(input logic [31:0] w);
      wordData <= w;
      wordValid <= 1'b1;
      pos = pos + 32'h00000004;
      do @(negedge clk); while (wordReady !== 1'b1);
      @(posedge clk);
   endtask : send

   // wait, bounded, for a flag while the stream is idle
   task automatic wait_hi(ref logic s);
      wordValid <= 1'b0;
      for (int i = 0; i < 300 && s !== 1'b1; i++) @(negedge clk);
   endtask : wait_hi

   task automatic settle();
      wordValid <= 1'b0;
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if (wrQ.size() == 0 && wordReady === 1'b1) break;
      end
      @(posedge clk);
   endtask : settle

   // load or fill section; notes each expected write word
   task automatic section(input logic [31:0] op, a, n, wd, p);
      logic [31:0] d;
      logic [31:0] r;
      send(op);
      send(a);
      send(n);
      if (op == bsci_pkg::OPC_SECTION_FILL) send(wd);
      for (logic [31:0] i = 0; i < n; i += 4) begin
         r = n - i;
         d = wd == bsci_pkg::FILL_W8 ? {4{p[7:0]}} :
            wd == bsci_pkg::FILL_W16 ? {2{p[15:0]}} : p;
         if (op == bsci_pkg::OPC_SECTION_LOAD) d = $random(seed);
         wrQ.push_back({a + i, d, r > 3 ? bsci_pkg::BE_ALL : r == 3 ?
            bsci_pkg::BE_3 : r == 2 ? bsci_pkg::BE_2 : bsci_pkg::BE_1});
         if (crcEn) crcM = crc_step(crcM, d);
         if (op == bsci_pkg::OPC_SECTION_LOAD) send(d);
      end
      if (op == bsci_pkg::OPC_SECTION_FILL) send(p);
      nsect++;
      nbytes += n;
   endtask : section

   task automatic crc_req(input logic [31:0] expv, seek, input logic bad);
      logic seen;
      seen = 1'b0;
      send(bsci_pkg::OPC_CRC_REQUEST);
      send(expv);
      send(seek);
      wordValid <= 1'b0;
      repeat (4) begin
         @(negedge clk);
         if (crcFail === 1'b1) seen = 1'b1;
      end
      if (bad) pos = pos + seek;
      if (bad && masterMode) crcM = 32'h00000000;
      check("seekReq", {31'h0, bad && masterMode}, {31'h0, seekReq});
      if (bad && masterMode) check("seekAddr", pos, seekAddr);
      check("crcFail", {31'h0, bad}, {31'h0, seen});
      check("streamPos", pos, streamPos);
      settle();
   endtask : crc_req

   // take the oldest note whenever a write is accepted
   always @(posedge clk) begin
      if (arst_n && memWrValid === 1'b1 && memWrReady === 1'b1) begin
         note = wrQ.size() > 0 ? wrQ.pop_front() : 68'h0;
         check("memWrAddr", note[67:36], memWrAddr);
         check("memWrData", note[35:4], memWrData);
         check("memWrBe", {28'h0, note[3:0]}, {28'h0, memWrBe});
      end
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end

   initial begin
      {pos, crcM, nsect, nbytes} = 128'h0;
      @(posedge clk);
      @(negedge clk);
      check("wordReady", 32'h1, {31'h0, wordReady});
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      send(bsci_pkg::OPC_CRC_ENABLE);
      crcEn = 1'b1;
      section(bsci_pkg::OPC_SECTION_LOAD, 32'h00800000, 8, 0, 0);
      section(bsci_pkg::OPC_SECTION_LOAD, 32'h00800100, 7, 0, 0);
      slow <= 1'b1;
      for (int k = 0; k < 3; k++)
         section(bsci_pkg::OPC_SECTION_FILL, 32'h00810000 + k * 256,
            5 + k, 32'h8 << k, $random(seed));
      settle();
      slow <= 1'b0;
      check("crcOn", 32'h1, {31'h0, crcOn});
      check("crcValue", crcM, crcValue);
      $display("TB test load and fill finished");
      crc_req(crcM, 32'hFFFFFFF0, 1'b0);
      section(bsci_pkg::OPC_SECTION_LOAD, 32'h00820000, 8, 0, 0);
      crc_req(~crcM, 32'hFFFFFFE0, 1'b1);
      send(bsci_pkg::OPC_RESTART_CHECKSUM_CMD);
      crcM = 32'h00000000;
      settle();
      check("crcValue", 32'h0, crcValue);
      section(bsci_pkg::OPC_SECTION_LOAD, 32'h00820000, 8, 0, 0);
      crc_req(crcM, 32'hFFFFFFE0, 1'b0);
      send(bsci_pkg::OPC_CRC_DISABLE);
      crcEn = 1'b0;
      section(bsci_pkg::OPC_SECTION_FILL, 32'h00830000, 4, 32'h20, 5);
      settle();
      check("crcOn", 32'h0, {31'h0, crcOn});
      check("crcValue", crcM, crcValue);
      $display("TB test checksum retry finished");
      send(bsci_pkg::OPC_JUMP);
      send(32'h00800000);
      wait_hi(jumpReq);
      check("jumpReq", 32'h1, {31'h0, jumpReq});
      check("jumpAddr", 32'h00800000, jumpAddr);
      settle();
      masterMode <= 1'b1;
      send(bsci_pkg::OPC_CRC_ENABLE);
      crcEn = 1'b1;
      section(bsci_pkg::OPC_SECTION_LOAD, 32'h00840000, 4, 0, 0);
      crc_req(~crcM, 32'hFFFFFFE4, 1'b1);
      check("crcValue", 32'h0, crcValue);
      $display("TB test jump and own seek finished");
      send(bsci_pkg::OPC_JUMP_CLOSE);
      send(32'h00800040);
      send(nsect);
      send(nbytes);
      wait_hi(bootDone);
      check("bootDone", 32'h1, {31'h0, bootDone});
      check("entryAddr", 32'h00800040, entryAddr);
      check("countMatch", 32'h1, {31'h0, countMatch});
      arst_n <= 1'b0;
      masterMode <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      send(32'h58535907);
      wait_hi(bootError);
      check("bootError", 32'h1, {31'h0, bootError});
      check("wordReady", 32'h0, {31'h0, wordReady});
      $display("TB test close and error finished");
      final_report();
   end
endmodule : testbench

bind bsci_interp bsci_properties i_props (.clk(clk), .arst_n(arst_n),
   .wordReady(wordReady), .masterMode(masterMode), .memWrValid(memWrValid),
   .memWrReady(memWrReady), .memWrAddr(memWrAddr), .memWrData(memWrData),
   .memWrBe(memWrBe), .jumpReq(jumpReq), .jumpAddr(jumpAddr),
   .jumpDone(jumpDone), .seekReq(seekReq), .seekAddr(seekAddr),
   .seekAck(seekAck), .crcFail(crcFail), .crcOn(crcOn), .crcValue(crcValue),
   .streamPos(streamPos), .bootDone(bootDone), .entryAddr(entryAddr),
   .bootError(bootError));
